//--- rtl/card_select_pkg.sv
// constants, types and fixed file/application tables for card selection
// assumes both ends import it; no clock or reset logic here
package card_select_pkg;

  // sizes
  localparam int CHANS = 4; // logical channels
  localparam int PATH_MAX = 4; // identifiers in one path
  localparam int NAME_BYTES = 16; // longest directory name
  localparam int NAME_MIN = 1; // shortest directory name
  localparam int NFILES = 8; // entries in the file table
  localparam int NAPPS = 2; // selectable applications
  localparam int STAMP_W = 8; // recency stamp width
  localparam int FIDX_W = 3; // file table index width
  localparam int AIDX_W = 1; // application index width

  // identifiers and parameter codes
  localparam logic [15:0] FID_MF = 16'h3f00; // master_file identifier
  localparam logic [15:0] FID_CUR_APP = 16'h7fff; // implicit active application directory
  localparam logic [7:0] P1_PARTIAL = 8'h04; // select by truncated name
  localparam logic [7:0] TAG_SHORT_ID = 8'h88; // control parameter object holding short_file_id
  localparam logic [4:0] SFI_NONE = 5'h00; // no short_file_id given / unsupported
  localparam logic [4:0] SFI_MIN = 5'h01;
  localparam logic [4:0] SFI_MAX = 5'h1e;
  localparam logic [1:0] OCC_FIRST = 2'h0; // occurrence choice in p2
  localparam logic [1:0] OCC_LAST = 2'h1;
  localparam logic [1:0] OCC_NEXT = 2'h2;
  localparam logic [1:0] OCC_PREV = 2'h3;

  // status words
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_BAD_PATH = 16'h6a80; // path breaks a restriction
  localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
  localparam logic [15:0] SW_PARAM = 16'h6a86; // parameters not supported
  localparam logic [15:0] SW_NO_EF = 16'h6986; // no current elementary_file
  localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
  localparam logic [15:0] SW_LOCAL = 16'h6f00; // refused inside the terminal

  // reset values
  localparam logic [FIDX_W-1:0] FIDX_MF = 3'h0; // master_file table index, all-zero reset
  localparam logic [7:0] PTR_RESET = 8'h00; // record / tag pointer not set

  // command kinds
  typedef enum logic [2:0] {
    op_path_mf, op_path_cur, op_name, op_sfi_bin, op_sfi_rec, op_sfi_tag, op_status
  } op_t;

  // one file: identifier, parent, kind, short id control object
  typedef struct packed {
    logic [15:0] file_identifier;
    logic [FIDX_W-1:0] parent;
    logic is_dir;
    logic tag_present; // object with TAG_SHORT_ID present
    logic [7:0] tag_len;
    logic [4:0] tag_sfi;
  } file_entry_t;

  // one application: left-aligned name, length, its directory
  typedef struct packed {
    logic [8*NAME_BYTES-1:0] name;
    logic [4:0] len;
    logic [FIDX_W-1:0] adf;
  } app_entry_t;

  localparam file_entry_t FILE_TABLE [NFILES] = '{
    '{16'h3f00, 3'h0, 1'b1, 1'b0, 8'h00, 5'h00}, // master_file
    '{16'h2f00, 3'h0, 1'b0, 1'b0, 8'h00, 5'h00}, // ef, low bits zero
    '{16'h7f01, 3'h0, 1'b1, 1'b0, 8'h00, 5'h00}, // application_directory a
    '{16'h7f10, 3'h0, 1'b1, 1'b0, 8'h00, 5'h00}, // plain directory
    '{16'h6f07, 3'h2, 1'b0, 1'b0, 8'h00, 5'h00}, // ef, id from low bits
    '{16'h6f20, 3'h2, 1'b0, 1'b1, 8'h01, 5'h03}, // ef, explicit id
    '{16'h6f38, 3'h3, 1'b0, 1'b1, 8'h00, 5'h00}, // ef, no short id
    '{16'h5f01, 3'h2, 1'b1, 1'b0, 8'h00, 5'h00}  // application_directory b
  };

  // names are arbitrary values
  localparam app_entry_t APP_TABLE [NAPPS] = '{
    '{{32'hd0112201, 96'h0}, 5'h04, 3'h2},
    '{{32'hd0112202, 96'h0}, 5'h04, 3'h7}
  };

endpackage : card_select_pkg

//--- rtl/card_select_if.sv
// command link between terminal end and card end
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface card_select_if
  import card_select_pkg::*;
#(
  parameter int CHANS = card_select_pkg::CHANS,
  parameter int PATH_MAX = card_select_pkg::PATH_MAX
);
  localparam int CH_W = $clog2(CHANS);
  localparam int PL_W = $clog2(PATH_MAX + 1);

  logic req_valid; // command offered
  logic req_ready; // card takes it
  op_t req_op;
  logic [CH_W-1:0] req_chan; // logical channel
  logic [7:0] req_p1;
  logic [1:0] req_occ; // occurrence choice
  logic [PATH_MAX-1:0][15:0] req_path; // element 0 first
  logic [PL_W-1:0] req_path_len;
  logic [4:0] req_sfi;
  logic [8*NAME_BYTES-1:0] req_name; // first byte in top bits
  logic [4:0] req_name_len;
  logic rsp_valid; // one-cycle answer
  logic [15:0] rsp_sw;
  logic [FIDX_W-1:0] rsp_file; // current file after command

  modport dev (
    input req_valid, req_op, req_chan, req_p1, req_occ, req_path, req_path_len,
    input req_sfi, req_name, req_name_len,
    output req_ready, rsp_valid, rsp_sw, rsp_file
  );
  modport term (
    output req_valid, req_op, req_chan, req_p1, req_occ, req_path, req_path_len,
    output req_sfi, req_name, req_name_len,
    input req_ready, rsp_valid, rsp_sw, rsp_file
  );
endinterface : card_select_if

//--- rtl/card_select_dev.sv
// card end: file selection, short-id selection, application selection
// assumes the transport delivers whole commands on the link, one at a time
// Notes on behaviour
// - 7FFF from master starts at active app
// - terminal never leads master path with 3F00
// - terminal never leads relative path with 7FFF
// - terminal never names current directory in path
// - terminal never sends an empty path
// - data commands with short id select file
// - tag 88 object holds short id
// - tag 88 with length zero: no short id
// - no tag 88: low five identifier bits
// - record commands with short id reset record pointer
// - data object commands with short id reset tag pointer
// - name select activates app, sets its directory
// - names one to sixteen bytes, all unique
// - p1 04 prefix match, p2 picks occurrence
// - last picks most recent matching application
// - multi-app cards support and advertise partial
// - unsupported partial select answers 6A86
// - activation starts session, security evaluated (no security evaluation here, only session_start)
// - terminal may report init done by status
// - one active application per channel
// - one application may run on many channels
// - after reset master current, no ef
// - short ids five bits, one to thirty
`timescale 1ns/100ps
module card_select_dev
  import card_select_pkg::*;
#(
  parameter int CHANS = card_select_pkg::CHANS,
  parameter int PATH_MAX = card_select_pkg::PATH_MAX,
  parameter bit PARTIAL_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  card_select_if.dev bus,
  output logic session_start,
  output logic [$clog2(CHANS)-1:0] session_chan,
  output logic [AIDX_W-1:0] session_app,
  output logic status_done,
  output logic partial_cap
);
  localparam int CH_W = $clog2(CHANS);
  localparam int PL_W = $clog2(PATH_MAX + 1);

  // result of a lookup: status and file index
  typedef struct packed {
    logic [15:0] sw;
    logic [FIDX_W-1:0] idx;
  } res_t;

  // whole state of the card end
  typedef struct packed {
    logic ready;
    logic rsp_valid;
    logic [15:0] rsp_sw;
    logic [FIDX_W-1:0] rsp_file;
    logic [CHANS-1:0][FIDX_W-1:0] cur_dir; // current directory per channel
    logic [CHANS-1:0][FIDX_W-1:0] cur_ef; // current ef per channel
    logic [CHANS-1:0] ef_sel; // a current ef exists
    logic [CHANS-1:0] app_on; // session active per channel
    logic [CHANS-1:0][AIDX_W-1:0] app_idx;
    logic [CHANS-1:0][7:0] rec_ptr; // record pointer, zero means not set
    logic [CHANS-1:0][7:0] tag_ptr; // tag pointer, zero means not set
    logic [NAPPS-1:0][STAMP_W-1:0] stamp; // last activation time per app
    logic [STAMP_W-1:0] stamp_ctr;
    logic session_start;
    logic [CH_W-1:0] session_chan;
    logic [AIDX_W-1:0] session_app;
    logic status_done;
    logic partial_cap;
  } state_t;

  state_t st;
  state_t next_st;

  // short id a file answers to, SFI_NONE when it has none
  function automatic logic [4:0] eff_sfi(input file_entry_t f);
    if (!f.tag_present) begin
      return f.file_identifier[4:0];
    end
    if (f.tag_len == 8'h00) begin
      return SFI_NONE;
    end
    return f.tag_sfi;
  endfunction : eff_sfi

  // exact or prefix comparison of a supplied name
  function automatic logic name_match(input app_entry_t a, input logic [8*NAME_BYTES-1:0] nm,
                                      input logic [4:0] len, input logic partial);
    logic ok;
    ok = partial ? (len <= a.len) : (len == a.len);
    for (int b = 0; b < NAME_BYTES; b++) begin
      if (b < int'(len) && nm[8*(NAME_BYTES-1-b) +: 8] != a.name[8*(NAME_BYTES-1-b) +: 8]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : name_match

  // constant check that no two names collide
  function automatic logic names_ok();
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NAPPS; i++) begin
      if (APP_TABLE[i].len < NAME_MIN || APP_TABLE[i].len > NAME_BYTES) begin
        ok = 1'b0;
      end
      for (int j = i + 1; j < NAPPS; j++) begin
        if (APP_TABLE[i].len == APP_TABLE[j].len && APP_TABLE[i].name == APP_TABLE[j].name) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction : names_ok

  // walk a path; a restriction breach met before any missing element stops with SW_BAD_PATH
  function automatic res_t resolve(input logic from_mf, input logic [PATH_MAX-1:0][15:0] path,
                                   input logic [PL_W-1:0] len, input logic [FIDX_W-1:0] cur,
                                   input logic on, input logic [FIDX_W-1:0] adf);
    res_t r;
    logic hit;
    r.sw = SW_OK;
    r.idx = from_mf ? FIDX_MF : cur;
    hit = 1'b0;
    if (len == '0) begin
      r.sw = SW_BAD_PATH;
    end else if (from_mf && path[0] == FID_MF) begin
      r.sw = SW_BAD_PATH;
    end else if (!from_mf && path[0] == FID_CUR_APP) begin
      r.sw = SW_BAD_PATH;
    end
    for (int i = 0; i < PATH_MAX; i++) begin
      if (i < int'(len) && r.sw == SW_OK) begin
        if (path[i] == FILE_TABLE[cur].file_identifier) begin
          r.sw = SW_BAD_PATH;
        end else if (i == 0 && from_mf && path[i] == FID_CUR_APP) begin
          // start at this channel's active application
          if (on) begin
            r.idx = adf;
          end else begin
            r.sw = SW_NOT_FOUND;
          end
        end else begin
          // child of the file reached so far
          hit = 1'b0;
          for (int j = 1; j < NFILES; j++) begin
            if (!hit && FILE_TABLE[r.idx].is_dir && FILE_TABLE[j].parent == r.idx
                && FILE_TABLE[j].file_identifier == path[i]) begin
              r.idx = FIDX_W'(j);
              hit = 1'b1;
            end
          end
          if (!hit) begin
            r.sw = SW_NOT_FOUND;
          end
        end
      end
    end
    return r;
  endfunction : resolve

  // ef under the current directory carrying a short id
  function automatic res_t find_sfi(input logic [FIDX_W-1:0] cur, input logic [4:0] short_file_id);
    res_t r;
    r.sw = SW_NOT_FOUND;
    r.idx = FIDX_MF;
    if (short_file_id < SFI_MIN || short_file_id > SFI_MAX) begin
      r.sw = SW_PARAM;
    end else begin
      for (int j = 1; j < NFILES; j++) begin
        if (r.sw != SW_OK && !FILE_TABLE[j].is_dir && FILE_TABLE[j].parent == cur
            && eff_sfi(FILE_TABLE[j]) == short_file_id) begin
          r.sw = SW_OK;
          r.idx = FIDX_W'(j);
        end
      end
    end
    return r;
  endfunction : find_sfi

  // refuse shapes the logic cannot serve
  if (CHANS < 2 || CHANS > 20) begin : g_bad_chans
    $error("channel count out of range");
  end
  if (PATH_MAX < 1 || $bits(bus.req_path_len) != PL_W || $bits(bus.req_chan) != CH_W) begin : g_bad_link
    $error("link widths do not match");
  end
  if (NAPPS > 1 && !PARTIAL_EN) begin : g_bad_partial
    $error("multi-application card needs partial name select");
  end
  if (!names_ok()) begin : g_bad_names
    $error("application names must be 1..16 bytes and unique");
  end

  // working values of the command decode
  logic [CH_W-1:0] ch;
  res_t pr;
  logic partial;
  logic got;
  logic take;
  logic [AIDX_W-1:0] sel;
  logic [STAMP_W-1:0] best;

  // command decode and next state
  always_comb begin
    next_st = st;
    next_st.ready = 1'b1;
    next_st.partial_cap = PARTIAL_EN;
    next_st.rsp_valid = 1'b0;
    next_st.session_start = 1'b0;
    next_st.status_done = 1'b0;
    ch = bus.req_chan;
    pr = '{sw: SW_OK, idx: FIDX_MF};
    partial = (bus.req_p1 == P1_PARTIAL);
    got = 1'b0;
    take = 1'b0;
    sel = '0;
    best = '0;
    if (bus.req_valid && st.ready) begin
      next_st.rsp_valid = 1'b1;
      unique case (bus.req_op)
        op_path_mf, op_path_cur: begin
          pr = resolve(bus.req_op == op_path_mf, bus.req_path, bus.req_path_len, st.cur_dir[ch],
                       st.app_on[ch], APP_TABLE[st.app_idx[ch]].adf);
          // failed paths leave the selection alone
          if (pr.sw == SW_OK) begin
            if (FILE_TABLE[pr.idx].is_dir) begin
              next_st.cur_dir[ch] = pr.idx;
              next_st.ef_sel[ch] = 1'b0;
            end else begin
              next_st.cur_dir[ch] = FILE_TABLE[pr.idx].parent;
              next_st.cur_ef[ch] = pr.idx;
              next_st.ef_sel[ch] = 1'b1;
              next_st.rec_ptr[ch] = PTR_RESET;
              next_st.tag_ptr[ch] = PTR_RESET;
            end
          end
        end
        op_sfi_bin, op_sfi_rec, op_sfi_tag: begin
          if (bus.req_sfi == SFI_NONE) begin
            // continuation works on the current ef
            if (!st.ef_sel[ch]) begin
              pr.sw = SW_NO_EF;
            end
          end else begin
            pr = find_sfi(st.cur_dir[ch], bus.req_sfi);
            if (pr.sw == SW_OK) begin
              next_st.cur_ef[ch] = pr.idx;
              next_st.ef_sel[ch] = 1'b1;
              if (bus.req_op == op_sfi_rec) begin
                next_st.rec_ptr[ch] = PTR_RESET;
              end
              if (bus.req_op == op_sfi_tag) begin
                next_st.tag_ptr[ch] = PTR_RESET;
              end
            end
          end
        end
        op_name: begin
          if (bus.req_name_len < 5'(NAME_MIN) || bus.req_name_len > 5'(NAME_BYTES)) begin
            pr.sw = SW_WRONG_LEN;
          end else if (partial && !PARTIAL_EN) begin
            pr.sw = SW_PARAM;
          end else begin
            // pick one matching application
            for (int j = 0; j < NAPPS; j++) begin
              take = 1'b0;
              if (name_match(APP_TABLE[j], bus.req_name, bus.req_name_len, partial)) begin
                if (!partial || bus.req_occ == OCC_FIRST) begin
                  take = !got;
                end else if (bus.req_occ == OCC_LAST) begin
                  take = !got || st.stamp[j] > best;
                end else if (bus.req_occ == OCC_NEXT) begin
                  take = !got && (!st.app_on[ch] || j > int'(st.app_idx[ch]));
                end else begin
                  take = !st.app_on[ch] || j < int'(st.app_idx[ch]);
                end
              end
              if (take) begin
                got = 1'b1;
                sel = AIDX_W'(j);
                best = st.stamp[j];
              end
            end
            if (!got) begin
              pr.sw = SW_NOT_FOUND;
            end else begin
              // replaces any session on this channel only
              next_st.app_on[ch] = 1'b1;
              next_st.app_idx[ch] = sel;
              next_st.cur_dir[ch] = APP_TABLE[sel].adf;
              next_st.ef_sel[ch] = 1'b0;
              next_st.stamp_ctr = st.stamp_ctr + 1'b1;
              next_st.stamp[sel] = st.stamp_ctr + 1'b1;
              next_st.session_start = 1'b1;
              next_st.session_chan = ch;
              next_st.session_app = sel;
              pr.idx = APP_TABLE[sel].adf;
            end
          end
        end
        op_status: begin
          next_st.status_done = 1'b1;
        end
        default: begin
          pr.sw = SW_PARAM;
        end
      endcase
      next_st.rsp_sw = pr.sw;
      next_st.rsp_file = next_st.ef_sel[ch] ? next_st.cur_ef[ch] : next_st.cur_dir[ch];
    end
  end

  // state register; zero means master current, no ef, no session
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign bus.req_ready = st.ready;
  assign bus.rsp_valid = st.rsp_valid;
  assign bus.rsp_sw = st.rsp_sw;
  assign bus.rsp_file = st.rsp_file;
  assign session_start = st.session_start;
  assign session_chan = st.session_chan;
  assign session_app = st.session_app;
  assign status_done = st.status_done;
  assign partial_cap = st.partial_cap;

endmodule : card_select_dev

//--- rtl/card_select_term.sv
// terminal end: screens paths, drops short ids on continuation, waits for answers
// assumes the user holds a command until cmd_ready and knows the current directory id
`timescale 1ns/100ps
module card_select_term
  import card_select_pkg::*;
#(
  parameter int CHANS = card_select_pkg::CHANS,
  parameter int PATH_MAX = card_select_pkg::PATH_MAX
) (
  input wire logic clk,
  input wire logic rst_n,
  card_select_if.term bus,
  input wire logic cmd_valid,
  input wire op_t cmd_op,
  input wire logic [$clog2(CHANS)-1:0] cmd_chan,
  input wire logic [7:0] cmd_p1,
  input wire logic [1:0] cmd_occ,
  input wire logic [PATH_MAX-1:0][15:0] cmd_path,
  input wire logic [$clog2(PATH_MAX+1)-1:0] cmd_path_len,
  input wire logic [4:0] cmd_sfi,
  input wire logic cmd_continue,
  input wire logic [8*NAME_BYTES-1:0] cmd_name,
  input wire logic [4:0] cmd_name_len,
  input wire logic [15:0] cur_dir_fid,
  output logic cmd_ready,
  output logic done,
  output logic [15:0] done_sw,
  output logic [FIDX_W-1:0] done_file
);
  localparam int CH_W = $clog2(CHANS);
  localparam int PL_W = $clog2(PATH_MAX + 1);

  typedef enum logic [1:0] {t_idle, t_send, t_wait} tstate_t;

  // whole state of the terminal end
  typedef struct packed {
    tstate_t fsm;
    logic cmd_ready;
    logic req_valid;
    op_t op;
    logic [CH_W-1:0] chan;
    logic [7:0] p1;
    logic [1:0] occ;
    logic [PATH_MAX-1:0][15:0] path;
    logic [PL_W-1:0] plen;
    logic [4:0] short_file_id;
    logic [8*NAME_BYTES-1:0] name;
    logic [4:0] nlen;
    logic done;
    logic [15:0] done_sw;
    logic [FIDX_W-1:0] done_file;
  } tstate_all_t;

  tstate_all_t st;
  tstate_all_t next_st;
  logic refuse;

  // true when a path breaks one of the path restrictions
  function automatic logic path_bad(input op_t op, input logic [PATH_MAX-1:0][15:0] p,
                                    input logic [PL_W-1:0] len, input logic [15:0] dir);
    logic bad;
    bad = (len == '0);
    bad = bad || (op == op_path_mf && p[0] == FID_MF);
    bad = bad || (op == op_path_cur && p[0] == FID_CUR_APP);
    for (int i = 0; i < PATH_MAX; i++) begin
      if (i < int'(len) && p[i] == dir) begin
        bad = 1'b1;
      end
    end
    return bad;
  endfunction : path_bad

  if (CHANS < 2 || PATH_MAX < 1) begin : g_bad_shape
    $error("terminal shape out of range");
  end

  // command sequencer
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    refuse = (cmd_op == op_path_mf || cmd_op == op_path_cur)
             && path_bad(cmd_op, cmd_path, cmd_path_len, cur_dir_fid);
    unique case (st.fsm)
      t_idle: begin
        if (cmd_valid && st.cmd_ready) begin
          next_st.op = cmd_op;
          next_st.chan = cmd_chan;
          next_st.p1 = cmd_p1;
          next_st.occ = cmd_occ;
          next_st.path = cmd_path;
          next_st.plen = cmd_path_len;
          next_st.short_file_id = cmd_continue ? SFI_NONE : cmd_sfi;
          next_st.name = cmd_name;
          next_st.nlen = cmd_name_len;
          if (refuse) begin
            // answered locally, never sent
            next_st.done = 1'b1;
            next_st.done_sw = SW_LOCAL;
            next_st.done_file = st.done_file;
          end else begin
            next_st.fsm = t_send;
            next_st.req_valid = 1'b1;
          end
        end
      end
      t_send: begin
        if (bus.req_ready) begin
          next_st.req_valid = 1'b0;
          next_st.fsm = t_wait;
        end
      end
      t_wait: begin
        if (bus.rsp_valid) begin
          next_st.done = 1'b1;
          next_st.done_sw = bus.rsp_sw;
          next_st.done_file = bus.rsp_file;
          next_st.fsm = t_idle;
        end
      end
    endcase
    next_st.cmd_ready = (next_st.fsm == t_idle);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // link and user outputs from the state register
  assign bus.req_valid = st.req_valid;
  assign bus.req_op = st.op;
  assign bus.req_chan = st.chan;
  assign bus.req_p1 = st.p1;
  assign bus.req_occ = st.occ;
  assign bus.req_path = st.path;
  assign bus.req_path_len = st.plen;
  assign bus.req_sfi = st.short_file_id;
  assign bus.req_name = st.name;
  assign bus.req_name_len = st.nlen;
  assign cmd_ready = st.cmd_ready;
  assign done = st.done;
  assign done_sw = st.done_sw;
  assign done_file = st.done_file;

endmodule : card_select_term

//--- bench/card_select_checker.sv
// link assertions between terminal end and card end
// assumes the signals of one card_select_if on a single clock
`timescale 1ns/100ps
module card_select_checker
  import card_select_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire op_t req_op,
  input wire logic [PATH_MAX-1:0][15:0] req_path,
  input wire logic [2:0] req_path_len,
  input wire logic [4:0] req_sfi,
  input wire logic [4:0] req_name_len,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_sw
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // command taken this edge
  wire take = req_valid && req_ready;
  wire is_path = req_op == op_path_mf || req_op == op_path_cur;
  // answer timing
  AST_RSP_NEXT: assert property (take |=> rsp_valid) else $error("no answer after take");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(take)) else $error("answer without take");
  // path screening by terminal
  AST_NO_MF_LEAD: assert property (req_valid && req_op == op_path_mf |-> req_path[0] != FID_MF)
    else $error("master path led by master id");
  AST_NO_APP_LEAD: assert property (req_valid && req_op == op_path_cur |-> req_path[0] != FID_CUR_APP)
    else $error("relative path led by app id");
  AST_PATH_LEN: assert property (req_valid && is_path |-> req_path_len != 3'h0)
    else $error("empty path sent");
  // device status words
  AST_SFI_RANGE: assert property (take && req_op == op_sfi_rec && req_sfi > SFI_MAX |=> rsp_sw == SW_PARAM)
    else $error("short id out of range accepted");
  AST_NAME_LEN: assert property (take && req_op == op_name && (req_name_len < NAME_MIN || req_name_len > NAME_BYTES)
    |=> rsp_sw == SW_WRONG_LEN)
    else $error("bad name length accepted");
  COV_NAME: cover property (take && req_op == op_name);
  COV_SFI: cover property (take && req_op == op_sfi_rec);
  COV_PATH: cover property (take && req_op == op_path_mf);
endmodule : card_select_checker

//--- bench/tb_top.sv
// testbench: terminal end and card end joined by the link
// assumes default table contents of card_select_pkg
`timescale 1ns/100ps
module tb_top;
  import card_select_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cont = 1'b0, cmd_ready, done, ss, pc, sd;
  op_t cmd_op = op_status;
  logic [1:0] cmd_chan = '0, cmd_occ = '0;
  logic [7:0] cmd_p1 = '0;
  logic [63:0] cmd_path = '0;
  logic [2:0] cmd_path_len = '0, done_file;
  logic [4:0] cmd_sfi = '0, cmd_name_len = '0;
  logic [31:0] nm = '0, r = 32'hc1ff7b52;
  logic [15:0] cd = 16'h3f00, done_sw;
  logic [19:0] x;
  int error_cnt = 0, comparisons = 0, sess = 0;
  card_select_if lnk ();
  card_select_dev card_select_dev_i (.clk(clk), .rst_n(rst_n), .bus(lnk), .session_start(ss),
    .session_chan(), .session_app(), .status_done(sd), .partial_cap(pc));
  card_select_term card_select_term_i (.clk(clk), .rst_n(rst_n), .bus(lnk), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_chan(cmd_chan), .cmd_p1(cmd_p1), .cmd_occ(cmd_occ), .cmd_path(cmd_path),
    .cmd_path_len(cmd_path_len), .cmd_sfi(cmd_sfi), .cmd_continue(cont), .cmd_name({nm, 96'h0}),
    .cmd_name_len(cmd_name_len), .cur_dir_fid(cd), .cmd_ready(cmd_ready), .done(done),
    .done_sw(done_sw), .done_file(done_file));
  card_select_checker card_select_checker_i (.clk(clk), .rst_n(rst_n), .req_valid(lnk.req_valid),
    .req_ready(lnk.req_ready), .req_op(lnk.req_op), .req_path(lnk.req_path),
    .req_path_len(lnk.req_path_len), .req_sfi(lnk.req_sfi), .req_name_len(lnk.req_name_len),
    .rsp_valid(lnk.rsp_valid), .rsp_sw(lnk.rsp_sw));
  // clock and counter of activations, plus sixteen per status report
  always #5 clk = ~clk;
  always @(posedge clk) sess += {sd === 1'b1, 3'h0, ss === 1'b1};
  function logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  // expected status and file for a short id under directory 2
  function logic [19:0] e(input logic [4:0] s);
    return s == 5'h03 ? {SW_OK, 4'h5} : s == 5'h07 ? {SW_OK, 4'h4} :
      s == 5'h1f ? {SW_PARAM, 4'h8} : {SW_NOT_FOUND, 4'h8};
  endfunction : e
  task chk(input string n, input logic [15:0] ex, input logic [15:0] s);
    comparisons++;
    if (s !== ex) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, ex, s);
    end
  endtask : chk
  // one command, then its answer; ef bit 3 set skips the file check
  task go(input op_t o, input logic [1:0] ch, input logic [7:0] p1, input logic [1:0] oc,
    input logic [63:0] pa, input logic [2:0] pl, input logic [4:0] sf, input logic [31:0] n,
    input logic [4:0] nl, input logic [15:0] esw, input logic [3:0] ef);
    @(negedge clk);
    {cmd_valid, cmd_chan, cmd_p1, cmd_occ} = {1'b1, ch, p1, oc};
    cmd_op = o;
    {cmd_path, cmd_path_len, cmd_sfi, nm, cmd_name_len} = {pa, pl, sf, n, nl};
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < 9 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("done", 16'h1, done);
    chk("rdy", 16'h1, cmd_ready);
    chk("sw", esw, done_sw);
    if (!ef[3]) chk("file", ef, done_file);
  endtask : go
  task wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    @(negedge clk);
    chk("cap", 16'h1, pc);
    go(op_sfi_bin, 0, 0, 0, 0, 0, 0, 0, 0, SW_NO_EF, 0);
    go(op_path_mf, 0, 0, 0, 'h7fff, 1, 0, 0, 0, SW_NOT_FOUND, 0);
    go(op_name, 0, 0, 0, 0, 0, 0, 32'hd0112201, 4, SW_OK, 2);
    cd = 16'h7f01;
    go(op_path_mf, 0, 0, 0, 'h6f077fff, 2, 0, 0, 0, SW_OK, 4);
    go(op_sfi_rec, 0, 0, 0, 0, 0, 3, 0, 0, SW_OK, 5);
    go(op_sfi_tag, 0, 0, 0, 0, 0, 7, 0, 0, SW_OK, 4);
    cont = 1'b1;
    go(op_sfi_tag, 0, 0, 0, 0, 0, 3, 0, 0, SW_OK, 4);
    cont = 1'b0;
    go(op_sfi_rec, 0, 0, 0, 0, 0, 31, 0, 0, SW_PARAM, 4);
    for (int k = 0; k < 12; k++) begin
      r = xs(r);
      x = e(5'(r % 31 + 1));
      go(op_sfi_rec, 0, 0, 0, 0, 0, 5'(r % 31 + 1), 0, 0, x[19:4], x[3:0]);
    end
    go(op_path_mf, 0, 0, 0, 'h7f10, 1, 0, 0, 0, SW_OK, 3);
    cd = 16'h7f10;
    go(op_sfi_rec, 0, 0, 0, 0, 0, 24, 0, 0, SW_NOT_FOUND, 3);
    go(op_path_mf, 0, 0, 0, 'h6f383f00, 2, 0, 0, 0, SW_LOCAL, 3);
    go(op_path_cur, 0, 0, 0, 'h7fff, 1, 0, 0, 0, SW_LOCAL, 3);
    go(op_path_cur, 0, 0, 0, 'h6f38, 0, 0, 0, 0, SW_LOCAL, 3);
    go(op_path_mf, 0, 0, 0, 'h7f10, 1, 0, 0, 0, SW_LOCAL, 3);
    go(op_path_cur, 0, 0, 0, 'h6f38, 1, 0, 0, 0, SW_OK, 6);
    go(op_name, 0, 0, 0, 0, 0, 0, 32'hd0112201, 0, SW_WRONG_LEN, 6);
    go(op_name, 0, 0, 0, 0, 0, 0, 32'hd0112201, 17, SW_WRONG_LEN, 6);
    go(op_name, 1, P1_PARTIAL, OCC_FIRST, 0, 0, 0, 32'hd0112200, 3, SW_OK, 2);
    go(op_name, 1, P1_PARTIAL, OCC_NEXT, 0, 0, 0, 32'hd0112200, 3, SW_OK, 7);
    go(op_name, 1, P1_PARTIAL, OCC_LAST, 0, 0, 0, 32'hd0112200, 3, SW_OK, 7);
    go(op_name, 1, P1_PARTIAL, OCC_PREV, 0, 0, 0, 32'hd0112200, 3, SW_OK, 2);
    go(op_name, 1, P1_PARTIAL, OCC_NEXT, 0, 0, 0, 32'hd0112200, 3, SW_OK, 7);
    go(op_path_mf, 0, 0, 0, 'h7fff, 1, 0, 0, 0, SW_OK, 2);
    go(op_status, 0, 0, 0, 0, 0, 0, 0, 0, SW_OK, 2);
    go(op_path_mf, 1, 0, 0, 'h7fff, 1, 0, 0, 0, SW_OK, 7);
    chk("sess", 16'h16, 16'(sess));
    wrap_up();
  end
endmodule : tb_top
